/* File: core/scr_pkg.sv */
/*
 * scr_pkg: shared constants and types of the charger command register bank.
 * Assumes a single 10 MHz clock domain; all times are converted to cycles here.
 */
package scr_pkg;

   // ******************************************************************
   // clock and times
   // ******************************************************************
   localparam int unsigned CLK_HZ      = 10_000_000;
   localparam int unsigned DG_SHORT_MS = 150;
   localparam int unsigned DG_LONG_MS  = 1300;
   localparam int unsigned WD_1_S      = 44;
   localparam int unsigned WD_2_S      = 88;
   localparam int unsigned WD_3_S      = 175;

   localparam logic [31:0] DG_SHORT_CYC = 32'(64'(DG_SHORT_MS) * 64'(CLK_HZ) / 64'd1000);
   localparam logic [31:0] DG_LONG_CYC  = 32'(64'(DG_LONG_MS) * 64'(CLK_HZ) / 64'd1000);
   localparam logic [31:0] WD_1_CYC     = 32'(64'(WD_1_S) * 64'(CLK_HZ));
   localparam logic [31:0] WD_2_CYC     = 32'(64'(WD_2_S) * 64'(CLK_HZ));
   localparam logic [31:0] WD_3_CYC     = 32'(64'(WD_3_S) * 64'(CLK_HZ));

   // ******************************************************************
   // command codes and reset values
   // ******************************************************************
   localparam logic [7:0]  CMD_OPT     = 8'h12;
   localparam logic [7:0]  CMD_CUR     = 8'h14;
   localparam logic [7:0]  CMD_VOLT    = 8'h15;
   localparam logic [7:0]  CMD_INLIM   = 8'h3f;
   localparam logic [7:0]  CMD_MAKER   = 8'hfe;
   localparam logic [7:0]  CMD_PART    = 8'hff;
   localparam logic [15:0] OPT_RESET   = 16'hf902;
   localparam logic [15:0] CUR_RESET   = 16'h0000;
   localparam logic [15:0] VOLT_RESET  = 16'h0000;
   localparam logic [15:0] INLIM_RESET = 16'h1000;
   localparam logic [15:0] OPT_WR_MASK = 16'hffef;
   localparam logic [15:0] UNMAPPED_RD = 16'h0000;
   // arbitrary neutral identification values
   localparam logic [15:0] MAKER_CODE_DEF = 16'h00a5;
   localparam logic [15:0] PART_CODE_DEF  = 16'h005a;
   localparam logic [6:0]  SMB_ADDR_DEF   = 7'h09;

   // ******************************************************************
   // field positions
   // ******************************************************************
   localparam int OPT_DG_LONG = 15;
   localparam int OPT_WD_LO   = 13;
   localparam int OPT_FREQ_UP = 10;
   localparam int OPT_FREQ_EN = 9;
   localparam int OPT_HS_EN   = 8;
   localparam int OPT_LS_HI   = 7;
   localparam int OPT_AC_IND  = 4;
   localparam int OPT_OC_EN   = 1;
   localparam int CUR_LSB     = 6;
   localparam int CUR_W       = 7;
   localparam int VOLT_LSB    = 4;
   localparam int VOLT_W      = 11;
   localparam int INLIM_LSB   = 7;
   localparam int INLIM_W     = 6;

   localparam logic [1:0] WD_OFF = 2'b00;
   localparam logic [1:0] WD_1   = 2'b01;
   localparam logic [1:0] WD_2   = 2'b10;

   // ******************************************************************
   // types
   // ******************************************************************
   typedef enum logic [6:0] {
      ST_IDLE  = 7'b0000001,
      ST_ADDR  = 7'b0000010,
      ST_CMD   = 7'b0000100,
      ST_WDATA = 7'b0001000,
      ST_ACK   = 7'b0010000,
      ST_RDATA = 7'b0100000,
      ST_RACK  = 7'b1000000
   } scr_smb_t;

   typedef enum logic [2:0] {
      PH_ADDR = 3'b001,
      PH_CMD  = 3'b010,
      PH_DATA = 3'b100
   } scr_phase_t;

   typedef struct packed {
      logic scl;
      logic sda;
      logic detect;
      logic supply;
      logic sw_on;
   } scr_pins_t;

   typedef struct packed {
      scr_pins_t  m0;
      scr_pins_t  m1;
      scr_pins_t  m2;
      scr_pins_t  f;
      scr_smb_t   st;
      scr_phase_t ph;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [7:0] tx;
      logic [7:0] cmd;
      logic [7:0] lo;
      logic       rd;
      logic       mack;
      logic       bidx;
      logic       oe;
      logic [15:0] opt;
      logic [CUR_W-1:0]   cur;
      logic [VOLT_W-1:0]  volt;
      logic [INLIM_W-1:0] inl;
      logic [31:0] wd;
      logic        susp;
   } scr_state_t;

   typedef struct packed {
      logic [31:0] cnt;
      logic        flag;
      logic        off_seen;
      logic        sw_d;
   } scr_dg_state_t;

endpackage

/* File: core/scr_deglitch.sv */
/*
 * scr_deglitch: rising-edge deglitch of the adapter-present flag.
 * Assumes its inputs are already synchronised to i_clk.
 */
`timescale 1ns/10ps
module scr_deglitch
   import scr_pkg::*;
#(
   parameter logic [31:0] P_SHORT = DG_SHORT_CYC,
   parameter logic [31:0] P_LONG  = DG_LONG_CYC
)(
   input  wire logic i_clk,
   input  wire logic i_rst,
   input  wire logic i_raw,
   input  wire logic i_long_sel,
   input  wire logic i_switch_on,
   output logic      o_flag
);

   scr_dg_state_t s;
   scr_dg_state_t next_s;
   logic [31:0]   limit;

   if (P_SHORT == 32'h0 || P_LONG == 32'h0) begin : g_chk
      $error("deglitch counts must be nonzero");
   end

   always_comb begin
      next_s = s;
      next_s.sw_d = i_switch_on;
      if (s.sw_d && !i_switch_on) begin
         next_s.off_seen = 1'b1;
      end
      // long time only once the switch has opened at least once
      limit = (s.off_seen && i_long_sel) ? P_LONG : P_SHORT;
      if (!i_raw) begin
         next_s.cnt  = 32'h0;
         next_s.flag = 1'b0;
      end else if (!s.flag) begin
         if (s.cnt >= limit - 32'h1) begin
            next_s.flag = 1'b1;
         end else begin
            next_s.cnt = s.cnt + 32'h1;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign o_flag = s.flag;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   a_first_short: assert property (
      (i_raw && !s.flag && !s.off_seen && s.cnt == P_SHORT - 32'h1) |=> s.flag)
      else $error("first insertion did not use short deglitch");
   a_long_select: assert property (
      (i_raw && !s.flag && s.off_seen && i_long_sel && s.cnt == P_SHORT - 32'h1
       && P_LONG > P_SHORT) |=> !s.flag)
      else $error("long deglitch ended early");
   a_raw_drop: assert property (
      !i_raw |=> !s.flag && s.cnt == 32'h0)
      else $error("flag stayed up after adapter loss");

endmodule // scr_deglitch

/* File: core/scr_regs.sv */
/*
 * scr_regs: word command register bank of a charge controller on an SMBus
 * slave port, with the charge watchdog and adapter-present deglitch.
 * Assumes SCL/SDA and the analog status levels arrive asynchronously and
 * that the open-drain SDA wire is resolved outside from o_sda_oe.
 */
// How it works
// - six word commands, word read/write only
// - maker query returns fixed code, read-only
// - part query returns fixed code, read-only
// - option word read/write, resets 0xf902
// - charge current 7 bits, resets zero
// - charge voltage 11 bits, resets zero
// - input limit 6 bits, resets 0x1000
// - first insertion always deglitched 150 ms
// - select bit acts after switch opened once
// - bit 15 picks 150 ms or 1.3 s
// - bus ignored unless supply and detect good
// - watchdog timeout suspends charging
// - voltage or current write resumes charging
// - bits 14:13 choose watchdog period
// - bit 1 enables input overcurrent latch-off
// - bits 9,10 adjust switching frequency
// - bits 7,8 set short-circuit thresholds
`timescale 1ns/10ps
module scr_regs
   import scr_pkg::*;
#(
   parameter logic [6:0]  P_SMB_ADDR   = SMB_ADDR_DEF,
   parameter logic [15:0] P_MAKER_CODE = MAKER_CODE_DEF,
   parameter logic [15:0] P_PART_CODE  = PART_CODE_DEF,
   parameter logic [31:0] P_DG_SHORT   = DG_SHORT_CYC,
   parameter logic [31:0] P_DG_LONG    = DG_LONG_CYC,
   parameter logic [31:0] P_WD_1       = WD_1_CYC,
   parameter logic [31:0] P_WD_2       = WD_2_CYC,
   parameter logic [31:0] P_WD_3       = WD_3_CYC
)(
   input  wire logic                i_clk,
   input  wire logic                i_rst,
   input  wire logic                i_scl,
   input  wire logic                i_sda,
   input  wire logic                i_adapter_detect_input,
   input  wire logic                i_supply_ok,
   input  wire logic                i_adapter_input_switch,
   output logic                     o_sda_out,
   output logic                     o_sda_oe,
   output logic                     o_adapter_present_flag,
   output logic                     o_charge_suspended,
   output logic [15:0]              o_charger_option_word,
   output logic [CUR_W-1:0]         o_charge_current_setting,
   output logic [VOLT_W-1:0]        o_charge_voltage_setting,
   output logic [INLIM_W-1:0]       o_input_current_limit,
   output logic                     o_input_overcurrent_guard_en,
   output logic                     o_freq_adjust_en,
   output logic                     o_freq_raise,
   output logic                     o_low_side_short_threshold,
   output logic                     o_high_side_short_threshold
);

   // ******************************************************************
   // state and helpers
   // ******************************************************************
   scr_state_t  s;
   scr_state_t  next_s;
   scr_pins_t   pins_in;
   scr_pins_t   next_f;
   logic        scl_rise;
   logic        scl_fall;
   logic        bus_start;
   logic        bus_stop;
   logic        bus_ok;
   logic        vi_wr;
   logic        do_wr;
   logic [15:0] wr_data;
   logic [15:0] rd_word;
   logic [31:0] period;
   logic        flag;

   if (P_WD_1 == 32'h0 || P_WD_2 == 32'h0 || P_WD_3 == 32'h0) begin : g_chk
      $error("watchdog counts must be nonzero");
   end

   assign pins_in = '{scl: i_scl, sda: i_sda, detect: i_adapter_detect_input,
                      supply: i_supply_ok, sw_on: i_adapter_input_switch};

   // filtered level moves only when stages two and three agree
   for (genvar g = 0; g < $bits(scr_pins_t); g++) begin : g_sync
      assign next_f[g] = (s.m1[g] == s.m2[g]) ? s.m2[g] : s.f[g];
   end

   // ******************************************************************
   // next-state logic
   // ******************************************************************
   always_comb begin
      next_s    = s;
      do_wr     = 1'b0;
      vi_wr     = 1'b0;
      wr_data   = {s.sh, s.lo};
      period    = P_WD_3;
      next_s.m0 = pins_in;
      next_s.m1 = s.m0;
      next_s.m2 = s.m1;
      next_s.f  = next_f;
      scl_rise  = !s.f.scl && next_f.scl;
      scl_fall  = s.f.scl && !next_f.scl;
      bus_start = s.f.scl && next_f.scl && s.f.sda && !next_f.sda;
      bus_stop  = s.f.scl && next_f.scl && !s.f.sda && next_f.sda;
      bus_ok    = s.f.supply && s.f.detect;

      // readback; the adapter indication bit shows live state
      if (s.cmd == CMD_OPT) begin
         rd_word = s.opt;
         rd_word[OPT_AC_IND] = flag;
      end else if (s.cmd == CMD_CUR) begin
         rd_word = 16'(s.cur) << CUR_LSB;
      end else if (s.cmd == CMD_VOLT) begin
         rd_word = 16'(s.volt) << VOLT_LSB;
      end else if (s.cmd == CMD_INLIM) begin
         rd_word = 16'(s.inl) << INLIM_LSB;
      end else if (s.cmd == CMD_MAKER) begin
         rd_word = P_MAKER_CODE;
      end else if (s.cmd == CMD_PART) begin
         rd_word = P_PART_CODE;
      end else begin
         rd_word = UNMAPPED_RD;
      end

      case (s.st)
         ST_IDLE: begin
         end
         ST_ADDR, ST_CMD, ST_WDATA: begin
            if (scl_rise) begin
               next_s.sh  = {s.sh[6:0], next_f.sda};
               next_s.cnt = s.cnt + 4'h1;
            end
            if (scl_fall && s.cnt == 4'h8) begin
               next_s.cnt = 4'h0;
               next_s.st  = ST_ACK;
               next_s.oe  = 1'b1;
               if (s.st == ST_ADDR) begin
                  next_s.ph = PH_ADDR;
                  next_s.rd = s.sh[0];
                  if (s.sh[7:1] != P_SMB_ADDR) begin
                     next_s.st = ST_IDLE;
                     next_s.oe = 1'b0;
                  end
               end else if (s.st == ST_CMD) begin
                  next_s.ph  = PH_CMD;
                  next_s.cmd = s.sh;
               end else begin
                  next_s.ph = PH_DATA;
                  if (!s.bidx) begin
                     next_s.lo = s.sh;
                  end else begin
                     do_wr = 1'b1;
                  end
               end
            end
         end
         ST_ACK: begin
            if (scl_fall) begin
               next_s.oe = 1'b0;
               case (s.ph)
                  PH_ADDR: begin
                     if (s.rd) begin
                        // low byte goes out first
                        next_s.tx   = rd_word[7:0];
                        next_s.oe   = !rd_word[7];
                        next_s.bidx = 1'b0;
                        next_s.st   = ST_RDATA;
                     end else begin
                        next_s.st = ST_CMD;
                     end
                  end
                  PH_CMD: begin
                     next_s.bidx = 1'b0;
                     next_s.st   = ST_WDATA;
                  end
                  default: begin
                     next_s.bidx = 1'b1;
                     next_s.st   = s.bidx ? ST_IDLE : ST_WDATA;
                  end
               endcase
            end
         end
         ST_RDATA: begin
            if (scl_rise) begin
               next_s.cnt = s.cnt + 4'h1;
            end
            if (scl_fall) begin
               if (s.cnt == 4'h8) begin
                  next_s.oe  = 1'b0;
                  next_s.cnt = 4'h0;
                  next_s.st  = ST_RACK;
               end else begin
                  next_s.tx = {s.tx[6:0], 1'b0};
                  next_s.oe = !s.tx[6];
               end
            end
         end
         ST_RACK: begin
            if (scl_rise) begin
               next_s.mack = !next_f.sda;
            end
            if (scl_fall) begin
               if (s.mack && !s.bidx) begin
                  next_s.bidx = 1'b1;
                  next_s.tx   = rd_word[15:8];
                  next_s.oe   = !rd_word[15];
                  next_s.st   = ST_RDATA;
               end else begin
                  next_s.st = ST_IDLE;
               end
            end
         end
         default: begin
            next_s.st = ST_IDLE;
            next_s.oe = 1'b0;
         end
      endcase

      if (bus_start) begin
         next_s.st   = ST_ADDR;
         next_s.cnt  = 4'h0;
         next_s.bidx = 1'b0;
         next_s.oe   = 1'b0;
      end
      // no answer at all while supply or adapter detect is low
      if (bus_stop || !bus_ok) begin
         next_s.st = ST_IDLE;
         next_s.oe = 1'b0;
      end

      // word commit; identification words have no storage
      if (do_wr) begin
         if (s.cmd == CMD_OPT) begin
            next_s.opt = wr_data & OPT_WR_MASK;
         end else if (s.cmd == CMD_CUR) begin
            next_s.cur = wr_data[CUR_LSB +: CUR_W];
            vi_wr      = 1'b1;
         end else if (s.cmd == CMD_VOLT) begin
            next_s.volt = wr_data[VOLT_LSB +: VOLT_W];
            vi_wr       = 1'b1;
         end else if (s.cmd == CMD_INLIM) begin
            next_s.inl = wr_data[INLIM_LSB +: INLIM_W];
         end
      end

      // ****************************************************************
      // charge watchdog
      // ****************************************************************
      if (s.opt[OPT_WD_LO +: 2] == WD_1) begin
         period = P_WD_1;
      end else if (s.opt[OPT_WD_LO +: 2] == WD_2) begin
         period = P_WD_2;
      end
      if (vi_wr) begin
         next_s.wd   = 32'h0;
         next_s.susp = 1'b0;
      end else if (s.opt[OPT_WD_LO +: 2] == WD_OFF) begin
         next_s.wd   = 32'h0;
         next_s.susp = 1'b0;
      end else if (!s.susp) begin
         // >= so that shortening the period expires at once
         if (s.wd >= period - 32'h1) begin
            next_s.susp = 1'b1;
         end else begin
            next_s.wd = s.wd + 32'h1;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         s      <= '0;
         s.st   <= ST_IDLE;
         s.ph   <= PH_ADDR;
         s.opt  <= OPT_RESET;
         s.cur  <= CUR_RESET[CUR_LSB +: CUR_W];
         s.volt <= VOLT_RESET[VOLT_LSB +: VOLT_W];
         s.inl  <= INLIM_RESET[INLIM_LSB +: INLIM_W];
      end else begin
         s <= next_s;
      end
   end

   scr_deglitch #(
      .P_SHORT (P_DG_SHORT),
      .P_LONG  (P_DG_LONG)
   ) u_deglitch (
      .i_clk       (i_clk),
      .i_rst       (i_rst),
      .i_raw       (s.f.detect),
      .i_long_sel  (s.opt[OPT_DG_LONG]),
      .i_switch_on (s.f.sw_on),
      .o_flag      (flag)
   );

   // ******************************************************************
   // outputs
   // ******************************************************************
   assign o_sda_out                    = 1'b0;
   assign o_sda_oe                     = s.oe;
   assign o_adapter_present_flag       = flag;
   assign o_charge_suspended           = s.susp;
   assign o_charger_option_word        = s.opt;
   assign o_charge_current_setting     = s.cur;
   assign o_charge_voltage_setting     = s.volt;
   assign o_input_current_limit        = s.inl;
   assign o_input_overcurrent_guard_en = s.opt[OPT_OC_EN];
   assign o_freq_adjust_en             = s.opt[OPT_FREQ_EN];
   assign o_freq_raise                 = s.opt[OPT_FREQ_UP];
   assign o_low_side_short_threshold   = s.opt[OPT_LS_HI];
   assign o_high_side_short_threshold  = s.opt[OPT_HS_EN];

   // ******************************************************************
   // checks
   // ******************************************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   sequence s_vi_write;
      vi_wr;
   endsequence
   sequence s_wd_last;
      !vi_wr && s.opt[OPT_WD_LO +: 2] != WD_OFF && !s.susp && s.wd == period - 32'h1;
   endsequence

   a_por_values: assert property (
      $fell(i_rst) |-> s.opt == OPT_RESET && s.cur == '0 && s.volt == '0
                       && 16'(s.inl) << INLIM_LSB == INLIM_RESET)
      else $error("register reset value wrong");
   a_id_ignored: assert property (
      (do_wr && s.cmd[7:1] == CMD_MAKER[7:1]) |=> $stable(s.opt) && $stable(s.cur)
                       && $stable(s.volt) && $stable(s.inl))
      else $error("identification write changed state");
   a_maker_read: assert property (
      (s.st == ST_ACK && s.ph == PH_ADDR && s.rd && scl_fall && bus_ok && !bus_start
       && s.cmd == CMD_MAKER) |=> s.tx == P_MAKER_CODE[7:0])
      else $error("maker code readback wrong");
   a_part_read: assert property (
      (s.st == ST_RACK && s.mack && !s.bidx && scl_fall && bus_ok && !bus_stop
       && s.cmd == CMD_PART) |=> s.tx == P_PART_CODE[15:8])
      else $error("part code readback wrong");
   a_lockout_quiet: assert property (
      !bus_ok |=> !s.oe && s.st == ST_IDLE)
      else $error("bus answered while locked out");
   a_wd_expire: assert property (
      s_wd_last |=> s.susp)
      else $error("watchdog did not suspend");
   a_wd_resume: assert property (
      s_vi_write |=> !s.susp && s.wd == 32'h0)
      else $error("write did not restart watchdog");
   a_wd_off: assert property (
      s.opt[OPT_WD_LO +: 2] == WD_OFF |=> !s.susp)
      else $error("disabled watchdog suspended charge");
   a_opt_write: assert property (
      (do_wr && s.cmd == CMD_OPT) |=> s.opt == ($past(wr_data) & OPT_WR_MASK))
      else $error("option word write lost");

endmodule // scr_regs

/* File: sim/scr_host.sv */
/*
 * scr_host: SMBus host model issuing word writes and word reads.
 * Assumes the bench resolves the open-drain SDA wire with a pull-up.
 */
`timescale 1ns/10ps
module scr_host
   import scr_pkg::*;
(
   input  wire logic i_clk,
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda_pull
);
   // ******************************************************************
   // bus phases, half bit of 10 clocks
   // ******************************************************************
   initial begin
      o_scl      = 1'b1;
      o_sda_pull = 1'b0;
   end

   task automatic hp;
      repeat (10) @(negedge i_clk);
   endtask

   // serves as start and repeated start
   task automatic start;
      o_sda_pull = 1'b0;
      hp();
      o_scl = 1'b1;
      hp();
      o_sda_pull = 1'b1;
      hp();
      o_scl = 1'b0;
      repeat (2) @(negedge i_clk);
   endtask

   task automatic stop;
      o_sda_pull = 1'b1;
      hp();
      o_scl = 1'b1;
      hp();
      o_sda_pull = 1'b0;
      hp();
   endtask

   // data held 2 clocks past scl fall so the filter never sees a false start
   task automatic put(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= -1; i--) begin
         o_sda_pull = (i >= 0) ? ~b[i[2:0]] : 1'b0;
         hp();
         o_scl = 1'b1;
         hp();
         ack = ~i_sda;
         o_scl = 1'b0;
         repeat (2) @(negedge i_clk);
      end
   endtask

   task automatic get(input logic ack, output logic [7:0] b);
      for (int i = 7; i >= -1; i--) begin
         o_sda_pull = (i < 0) & ack;
         hp();
         o_scl = 1'b1;
         hp();
         if (i >= 0) b[i[2:0]] = i_sda;
         o_scl = 1'b0;
         repeat (2) @(negedge i_clk);
      end
      o_sda_pull = 1'b0;
   endtask

   task automatic wr_word(input logic [7:0] c, input logic [15:0] d, output logic ok);
      logic a0, a1, a2, a3;
      start();
      put({SMB_ADDR_DEF, 1'b0}, a0);
      put(c, a1);
      put(d[7:0], a2);
      put(d[15:8], a3);
      stop();
      ok = a0 & a1 & a2 & a3;
   endtask

   task automatic rd_word(input logic [7:0] c, output logic [15:0] d, output logic ok);
      logic a0, a1, a2;
      start();
      put({SMB_ADDR_DEF, 1'b0}, a0);
      put(c, a1);
      start();
      put({SMB_ADDR_DEF, 1'b1}, a2);
      get(1'b1, d[7:0]);
      get(1'b0, d[15:8]);
      stop();
      ok = a0 & a1 & a2;
   endtask
endmodule // scr_host

/* File: sim/scr_regs_test.sv */
/*
 * scr_regs_test: self-checking bench of the charger command register bank.
 * Assumes shortened deglitch and watchdog counts set at the instance.
 */
`timescale 1ns/10ps
module scr_regs_test
   import scr_pkg::*;
;
   // ******************************************************************
   // wiring
   // ******************************************************************
   logic clk, rst, detect, supply, sw, scl, pull, oe, flag, susp, oc, fe, fr, ls, hs, ok;
   logic [15:0] optw;
   logic [6:0]  curw;
   logic [10:0] voltw;
   logic [5:0]  inlw;
   int   mismatches  = 0;
   int   comparisons = 0;
   wire  sda = ~(oe | pull);
   logic [7:0]  cmds [7] = '{CMD_OPT, CMD_CUR, CMD_VOLT, CMD_INLIM, CMD_MAKER, CMD_PART, 8'h20};
   logic [15:0] rv0  [7] = '{16'hf912, 16'h0, 16'h0, 16'h1000, MAKER_CODE_DEF, PART_CODE_DEF, 16'h0};
   logic [15:0] rv1  [7] = '{16'hf912, 16'h1fc0, 16'h7ff0, 16'h1f80, MAKER_CODE_DEF, PART_CODE_DEF,
                            16'h0};

   scr_host host (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_pull(pull));

   scr_regs #(.P_DG_SHORT(32'd20), .P_DG_LONG(32'd50), .P_WD_1(32'd100), .P_WD_2(32'd200),
      .P_WD_3(32'd300)) DUT (
      .i_clk(clk), .i_rst(rst), .i_scl(scl), .i_sda(sda), .i_adapter_detect_input(detect),
      .i_supply_ok(supply), .i_adapter_input_switch(sw), .o_sda_out(), .o_sda_oe(oe),
      .o_adapter_present_flag(flag), .o_charge_suspended(susp), .o_charger_option_word(optw),
      .o_charge_current_setting(curw), .o_charge_voltage_setting(voltw),
      .o_input_current_limit(inlw),
      .o_input_overcurrent_guard_en(oc), .o_freq_adjust_en(fe), .o_freq_raise(fr),
      .o_low_side_short_threshold(ls), .o_high_side_short_threshold(hs));

   // ******************************************************************
   // tasks
   // ******************************************************************
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: bit got %b expected %b", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic rd(input logic [7:0] c, input logic [15:0] e);
      logic [15:0] d;
      logic        a;
      host.rd_word(c, d, a);
      chk1(a, 1'b1);
      chk16(d, e);
   endtask

   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      host.wr_word(c, d, ok);
      chk1(ok, 1'b1);
   endtask

   // flag must stay low at lo cycles and be up by hi cycles after replug
   task automatic replug(input int lo, input int hi);
      detect = 1'b0;
      cyc(5);
      detect = 1'b1;
      cyc(lo);
      chk1(flag, 1'b0);
      cyc(hi - lo);
      chk1(flag, 1'b1);
   endtask

   task automatic test_done;
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ******************************************************************
   // stimulus
   // ******************************************************************
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // whole run is about 30k cycles, so 8 ms leaves ample margin
   initial begin
      #8ms;
      mismatches++;
      test_done();
   end

   initial begin
      rst = 1'b1;
      detect = 1'b1;
      supply = 1'b1;
      sw = 1'b1;
      cyc(6);
      rst = 1'b0;
      cyc(10);
      chk1(flag, 1'b0);
      cyc(40);
      chk1(flag, 1'b1);
      for (int i = 0; i < 7; i++) rd(cmds[i], rv0[i]);
      replug(10, 40);
      sw = 1'b0;
      cyc(5);
      replug(40, 80);
      for (int i = 1; i < 7; i++) wr(cmds[i], 16'hffff);
      for (int i = 0; i < 7; i++) rd(cmds[i], rv1[i]);
      chk16(optw, 16'hf902);
      chk16(16'(curw), 16'h007f);
      chk16(16'(voltw), 16'h07ff);
      chk16(16'(inlw), 16'h003f);
      chk1(susp, 1'b1);
      wr(CMD_VOLT, 16'h0010);
      chk1(susp, 1'b0);
      cyc(200);
      chk1(susp, 1'b0);
      cyc(100);
      chk1(susp, 1'b1);
      wr(CMD_OPT, 16'h2902);
      rd(CMD_OPT, 16'h2912);
      wr(CMD_CUR, 16'hffff);
      chk1(susp, 1'b0);
      cyc(20);
      chk1(susp, 1'b0);
      cyc(40);
      chk1(susp, 1'b1);
      replug(10, 40);
      wr(CMD_OPT, 16'h0682);
      chk16({11'h0, oc, fe, fr, ls, hs}, 16'h001e);
      cyc(400);
      chk1(susp, 1'b0);
      supply = 1'b0;
      cyc(10);
      host.wr_word(CMD_CUR, 16'h0000, ok);
      chk1(ok, 1'b0);
      supply = 1'b1;
      cyc(10);
      rd(CMD_CUR, 16'h1fc0);
      test_done();
   end
endmodule // scr_regs_test
